//--- src/config_port_control.sv
// configuration port control: request, ready, done, mode latch, port lock, data path
`timescale 1ns/1ps
module config_port_control #(
  parameter int FIFO_DEPTH_P = cfg_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // pins from the configuration host
  input wire logic programRequestN,
  input wire logic [cfg_pkg::MODE_W-1:0] modePins,
  input wire logic configClock,
  input wire logic parChipSelN,
  input wire logic parWriteN,
  input wire logic [cfg_pkg::DATA_W-1:0] parData,
  output logic parBusy,
  // open-drain ready pin, enable low while driving
  input wire logic readyToConfigureNIn,
  output logic readyToConfigureNOut,
  output logic readyToConfigureNOeN,
  // open-drain done pin, enable low while driving
  input wire logic doneIn,
  output logic doneOut,
  output logic doneOeN,
  // from the test access port logic, same clock
  input wire logic tapConfigCmd,
  input wire logic tapDataValid,
  output logic tapDataReady,
  input wire logic [cfg_pkg::DATA_W-1:0] tapData,
  output logic tapRefused,
  // to the configuration engine
  output cfg_pkg::cfg_word_t cfgWord,
  output logic cfgWordValid,
  input wire logic cfgWordReady,
  input wire logic configComplete,
  // status
  output logic [cfg_pkg::MODE_W-1:0] latchedMode,
  output cfg_pkg::port_t lockedPort,
  output logic startupActive,
  output logic userMode,
  output logic dataOverrun,
  output logic doneSeen
);
  import cfg_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  pin_sample_t pinRaw; // pins as they arrive
  pin_sample_t pinSmp; // pins after two flip-flops
  pin_sample_t pinPrevReg; // previous synchronised sample, for edges
  logic doneSmp; // done wire level, synchronised

  assign pinRaw = '{progN: programRequestN, ready_to_configure_n: readyToConfigureNIn,
    config_clock: configClock, csN: parChipSelN, writeN: parWriteN,
    mode: modePins, data: parData};

  // every pin crosses two flip-flops before any logic reads it
  sync_2ff #(
    .W($bits(pin_sample_t)),
    .RST_VAL(SAMPLE_RST)
  ) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(pinRaw),
    .syncOut(pinSmp)
  );

  // done is a separate wire, also open drain, so other devices may hold it
  sync_2ff #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_done_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(doneIn),
    .syncOut(doneSmp)
  );

  // previous sample, taken from synchronised levels only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pinPrevReg <= SAMPLE_RST;
    end else begin
      pinPrevReg <= pinSmp;
    end
  end

  // ---------------------------------------------------------------
  // edge and level decode
  // ---------------------------------------------------------------
  // the configuration clock is sampled, not used as a clock; with a
  // 20 ns core period only a host clock well under the 50 MHz ceiling
  // is seen reliably
  wire cclkRise = pinSmp.config_clock & ~pinPrevReg.config_clock; // [R7]
  wire initRise = pinSmp.ready_to_configure_n & ~pinPrevReg.ready_to_configure_n;
  wire progLow = ~pinSmp.progN;

  // ---------------------------------------------------------------
  // sequence state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CLEAR, // ready pin held low, preparing
    ST_WAIT_INIT, // ready pin released, waiting for the wire to rise
    ST_LOAD, // taking configuration data
    ST_STARTUP, // done released, startup counting
    ST_USER // configured
  } cfg_state_t;

  cfg_state_t stateReg, stateNext;
  logic [CNT_W-1:0] cntReg, cntNext; // phase timer
  logic [MODE_W-1:0] latchedModeReg; // mode captured at ready rise
  port_t lockReg, lockNext; // owning port, cleared only by power-up reset
  logic overrunReg; // a pin beat met a full buffer
  logic tapRefusedReg; // last cycle's command was refused
  logic initDriveReg; // ready pin driven low
  logic doneDriveReg; // done pin driven low

  // ---------------------------------------------------------------
  // port selection and lock
  // ---------------------------------------------------------------
  // a test port command is honoured unless the pins already own the device
  wire tapAccept = tapConfigCmd & (lockReg != PORT_PINS); // [R5] [R6]
  wire tapReject = tapConfigCmd & (lockReg == PORT_PINS); // [R6]
  wire pinsAllowed = (lockReg != PORT_TAP); // [R6]
  wire tapAllowed = (lockReg == PORT_TAP); // [R6]

  // ---------------------------------------------------------------
  // data path into the buffer
  // ---------------------------------------------------------------
  cfg_word_t fifoIn; // word offered to the buffer
  logic fifoInValid; // a word is offered
  logic fifoInReady; // buffer has room
  wire inLoad = (stateReg == ST_LOAD);
  // pin beats count only in the mode captured at the ready rise
  wire modeIsParallel = (latchedModeReg == MODE_SLAVE_PARALLEL); // [R1]
  // a pin write beat is taken on a sampled clock rise with select and write low
  wire pinBeat = inLoad & modeIsParallel & pinsAllowed & cclkRise
    & ~pinSmp.csN & ~pinSmp.writeN;
  wire tapBeat = inLoad & tapAllowed & tapDataValid;
  // the pin host is told to wait by busy; a beat it sends anyway is lost
  wire pinDrop = pinBeat & ~fifoInReady;

  assign fifoIn.src = tapAllowed ? PORT_TAP : PORT_PINS;
  assign fifoIn.data = tapAllowed ? tapData : pinSmp.data;
  assign fifoInValid = tapAllowed ? tapBeat : pinBeat;
  assign tapDataReady = inLoad & tapAllowed & fifoInReady;

  // buffer between the slow link and the engine, which may stall
  sync_fifo #(
    .WIDTH($bits(cfg_word_t)),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(cfgWordValid),
    .outReady(cfgWordReady),
    .outData(cfgWord)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // program low or an accepted test command restarts from the clear phase
  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    lockNext = lockReg;
    if (progLow || tapAccept) begin
      stateNext = ST_CLEAR; // [R2] [R5]
      cntNext = CNT_ZERO;
      if (tapAccept) begin
        lockNext = PORT_TAP; // [R6]
      end
    end else begin
      case (stateReg)
        ST_CLEAR: begin
          // hold ready low for the whole preparation time
          if (cntReg == CLEAR_LAST) begin
            stateNext = ST_WAIT_INIT; // [R8]
            cntNext = CNT_ZERO;
          end else begin
            cntNext = cntReg + 1'b1;
          end
        end
        ST_WAIT_INIT: begin
          // another device on the wire may still hold ready low
          if (initRise) begin
            stateNext = ST_LOAD; // [R3]
          end
        end
        ST_LOAD: begin
          // the first pin beat claims the device for the pins
          if (pinBeat && lockReg == PORT_NONE) begin
            lockNext = PORT_PINS; // [R6]
          end
          if (configComplete) begin
            stateNext = ST_STARTUP; // [R4]
            cntNext = CNT_ZERO;
          end
        end
        ST_STARTUP: begin
          if (cntReg == STARTUP_LAST) begin
            stateNext = ST_USER;
          end else begin
            cntNext = cntReg + 1'b1;
          end
        end
        ST_USER: begin
          stateNext = ST_USER;
        end
        default: begin
          stateNext = ST_CLEAR;
          cntNext = CNT_ZERO;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // power-up reset is the only thing that frees the port lock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stateReg <= ST_CLEAR;
      cntReg <= CNT_ZERO;
      lockReg <= PORT_NONE; // [R6]
    end else begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      lockReg <= lockNext;
    end
  end

  // mode pins are taken on the ready wire's rising edge while waiting
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latchedModeReg <= MODE_RESET;
    end else if (stateReg == ST_WAIT_INIT && initRise && !progLow) begin
      latchedModeReg <= pinSmp.mode; // [R1]
    end
  end

  // overrun is sticky until the next restart; a new drop wins over the clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      overrunReg <= 1'b0;
    end else if (pinDrop) begin
      overrunReg <= 1'b1;
    end else if (stateNext == ST_CLEAR && stateReg != ST_CLEAR) begin
      overrunReg <= 1'b0;
    end
  end

  // refusal is reported as a one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tapRefusedReg <= 1'b0;
    end else begin
      tapRefusedReg <= tapReject; // [R6]
    end
  end

  // ---------------------------------------------------------------
  // open-drain pin drive
  // ---------------------------------------------------------------
  // ready is pulled low only while preparing; done is held low until startup
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      initDriveReg <= 1'b1;
      doneDriveReg <= 1'b1;
    end else begin
      initDriveReg <= (stateNext == ST_CLEAR); // [R3] [R8]
      doneDriveReg <= (stateNext != ST_STARTUP) && (stateNext != ST_USER); // [R4]
    end
  end

  // the drive value is always low; only the enable moves
  assign readyToConfigureNOut = 1'b0;
  assign readyToConfigureNOeN = ~initDriveReg; // [R3]
  assign doneOut = 1'b0;
  assign doneOeN = ~doneDriveReg; // [R4]

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  // busy follows buffer room so back-pressure reaches the pin host
  assign parBusy = ~fifoInReady;
  assign tapRefused = tapRefusedReg;
  assign latchedMode = latchedModeReg;
  assign lockedPort = lockReg;
  assign startupActive = (stateReg == ST_STARTUP);
  assign userMode = (stateReg == ST_USER);
  assign dataOverrun = overrunReg;
  assign doneSeen = doneSmp;

endmodule

//--- src/cfg_pkg.sv
// constants, types and timing for the configuration port control block
// How it works
// [R1] mode pins captured on ready pin rising edge
// [R2] program request low starts configuration sequence
// [R3] open-drain ready pin shows data can be accepted
// [R4] open-drain done pin released: complete, startup running
// [R5] test port command starts configuration after power-up
// [R6] first selected port stays locked until power-up
// [R7] host keeps configuration clock at most 50 MHz; sampled at the 50 MHz core rate, only a clock well under that is seen
// [R8] ready pin held low while preparing after request
package cfg_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 50; // core_clk rate
  localparam int CONFIG_CLOCK_MAX_MHZ = 50; // fastest configuration clock the host may apply
  localparam int CLEAR_TIME_NS = 2000; // least time ready pin is held low
  localparam int STARTUP_TIME_NS = 400; // least length of the startup phase
  // least times round up to whole cycles
  localparam int CLEAR_CYCLES = (CLEAR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_CYCLES = (STARTUP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12; // width of the phase counter
  localparam logic [CNT_W-1:0] CLEAR_LAST = CNT_W'(CLEAR_CYCLES - 1);
  localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

  // ---------------------------------------------------------------
  // modes and widths
  // ---------------------------------------------------------------
  localparam int MODE_W = 3; // mode pins are [2:0]
  localparam int DATA_W = 8; // parallel data width
  localparam int FIFO_DEPTH = 16; // words held between link and core
  localparam logic [MODE_W-1:0] MODE_SLAVE_PARALLEL = 3'h3; // mode code of slave parallel
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0; // latched mode after reset

  // which configuration port owns the device
  typedef enum logic [1:0] {PORT_NONE, PORT_PINS, PORT_TAP} port_t;

  // raw pin levels, synchronised as one group
  typedef struct packed {
    logic progN; // program request, active low
    logic ready_to_configure_n; // ready pin level as seen on the wire
    logic config_clock; // configuration clock from the host
    logic csN; // parallel chip select, active low
    logic writeN; // parallel write enable, active low
    logic [MODE_W-1:0] mode; // mode select pins
    logic [DATA_W-1:0] data; // parallel data pins
  } pin_sample_t;

  // idle pin levels: request, selects and strobes inactive
  localparam pin_sample_t SAMPLE_RST = '{progN: 1'b1, ready_to_configure_n: 1'b0, config_clock: 1'b0,
    csN: 1'b1, writeN: 1'b1, mode: 3'h0, data: 8'h00};

  // one configuration byte with its source port
  typedef struct packed {
    port_t src;
    logic [DATA_W-1:0] data;
  } cfg_word_t;

endpackage

//--- src/sync_2ff.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  // ---------------------------------------------------------------
  // stages
  // ---------------------------------------------------------------
  logic [W-1:0] stage1Reg; // metastable stage, read only by stage two

  // the first stage feeds nothing but the second
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1Reg <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end

endmodule

//--- src/sync_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] memReg [DEPTH]; // word store
  logic [AW-1:0] wrPtrReg; // next slot to fill
  logic [AW-1:0] rdPtrReg; // oldest word
  logic [AW:0] countReg; // words held
  wire doPush = inValid & inReady;
  wire doPop = outValid & outReady;

  // honest flags straight from the count
  assign inReady = (countReg != DEPTH_CNT);
  assign outValid = (countReg != '0);
  assign outData = memReg[rdPtrReg];

  // write side: storage needs no reset
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      memReg[wrPtrReg] <= inData;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
    end else begin
      if (doPush) begin
        wrPtrReg <= (wrPtrReg == LAST_IDX) ? '0 : wrPtrReg + 1'b1;
      end
      if (doPop) begin
        rdPtrReg <= (rdPtrReg == LAST_IDX) ? '0 : rdPtrReg + 1'b1;
      end
      if (doPush && !doPop) begin
        countReg <= countReg + 1'b1;
      end else if (doPop && !doPush) begin
        countReg <= countReg - 1'b1;
      end
    end
  end

endmodule

//--- bench/config_port_control_assertions.sv
// concurrent checks on the configuration port control block
`timescale 1ns/1ps
module config_port_control_assertions (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic programRequestN,
  input wire logic [cfg_pkg::MODE_W-1:0] modePins,
  input wire logic tapConfigCmd,
  input wire logic readyToConfigureNOeN,
  input wire logic doneOeN,
  input wire logic tapRefused,
  input wire logic [cfg_pkg::MODE_W-1:0] latchedMode,
  input wire cfg_pkg::port_t lockedPort,
  input wire logic startupActive,
  input wire logic userMode
);
  import cfg_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic [11:0] lowCnt; // cycles the ready pin has been held low
  // saturates so a long hold never wraps back to a small count
  always_ff @(posedge core_clk) begin
    if (sys_rst || readyToConfigureNOeN) lowCnt <= 12'h000;
    else if (lowCnt != 12'hfff) lowCnt <= lowCnt + 12'h001;
  end
  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  // request held long enough to pass the synchroniser
  sequence s_progLow;
    !programRequestN [*6];
  endsequence
  // startup runs with done released, then user mode follows
  sequence s_startup;
    (startupActive && doneOeN && !userMode) [*8] ##[11:13] userMode;
  endsequence
  property p_clearHold;
    $rose(readyToConfigureNOeN) |-> lowCnt >= CLEAR_LAST - 12'h002;
  endproperty
  a_clearHold: assert property (p_clearHold) else $error("ready released too early");
  property p_progClear;
    s_progLow |-> !readyToConfigureNOeN && !doneOeN;
  endproperty
  a_progClear: assert property (p_progClear) else $error("request did not clear");
  property p_modeLatch;
    $changed(latchedMode) |-> latchedMode == modePins && readyToConfigureNOeN;
  endproperty
  a_modeLatch: assert property (p_modeLatch) else $error("mode latched wrongly");
  property p_doneOrder;
    $rose(doneOeN) |-> startupActive;
  endproperty
  a_doneOrder: assert property (p_doneOrder) else $error("done released outside startup");
  property p_startup;
    $rose(startupActive) |-> s_startup;
  endproperty
  a_startup: assert property (p_startup) else $error("startup length wrong");
  property p_lockStay;
    lockedPort != PORT_NONE |=> $stable(lockedPort);
  endproperty
  a_lockStay: assert property (p_lockStay) else $error("port lock changed");
  property p_refuse;
    tapConfigCmd && lockedPort == PORT_PINS |=> tapRefused ##1 !tapRefused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("test port not refused");
  property p_tapCmd;
    tapConfigCmd && lockedPort != PORT_PINS |=>
      lockedPort == PORT_TAP && !readyToConfigureNOeN && !tapRefused;
  endproperty
  a_tapCmd: assert property (p_tapCmd) else $error("test port command lost");
endmodule

//--- bench/cfg_host_model.sv
// host-side model that drives the configuration pins
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic core_clk,
  output logic programRequestN,
  output logic [cfg_pkg::MODE_W-1:0] modePins,
  output logic configClock,
  output logic parChipSelN,
  output logic parWriteN,
  output logic [cfg_pkg::DATA_W-1:0] parData
);
  import cfg_pkg::*;
  // idle levels: no request, link clock still, bus deselected
  initial begin
    programRequestN = 1'b1;
    modePins = MODE_SLAVE_PARALLEL; // strapped, static during the run
    configClock = 1'b0;
    parChipSelN = 1'b1;
    parWriteN = 1'b1;
    parData = 8'ha5;
  end
  // one write beat; 160 ns period keeps well below the 50 MHz ceiling
  // eight core cycles a beat; select drops two cycles before the clock rise takes it
  task automatic send_beat(input logic [DATA_W-1:0] v);
    parChipSelN <= 1'b0;
    parWriteN <= 1'b0;
    parData <= v;
    repeat (2) @(posedge core_clk);
    configClock <= 1'b1;
    repeat (4) @(posedge core_clk);
    configClock <= 1'b0;
    @(posedge core_clk);
    parChipSelN <= 1'b1;
    parWriteN <= 1'b1;
    parData <= ~v; // released bus must not show the old byte
    @(posedge core_clk);
  endtask
  // low pulse asks for reconfiguration
  task automatic pulse_program();
    programRequestN <= 1'b0;
    repeat (10) @(posedge core_clk);
    programRequestN <= 1'b1;
  endtask
endmodule

//--- bench/config_port_control_tb.sv
// self-checking bench for the configuration port control block
`timescale 1ns/1ps
module config_port_control_tb;
  import cfg_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tapConfigCmd = 1'b0;
  logic tapDataValid = 1'b0;
  logic cfgWordReady = 1'b0;
  logic configComplete = 1'b0;
  logic [DATA_W-1:0] tapData = 8'h00;
  logic programRequestN, configClock, parChipSelN, parWriteN, parBusy;
  logic [MODE_W-1:0] modePins, latchedMode;
  logic [DATA_W-1:0] parData, d;
  logic readyToConfigureNOut, readyToConfigureNOeN, doneOut, doneOeN, tapDataReady;
  logic tapRefused, cfgWordValid, startupActive, userMode, dataOverrun, doneSeen;
  logic readyWire, doneWire;
  cfg_word_t cfgWord;
  port_t lockedPort;
  cfg_word_t expQ[$]; // words the engine should receive, oldest first
  int err_count = 0;
  int n_checks = 0;
  int seed = 64530;
  int k;
  always #10 core_clk = ~core_clk;
  // open-drain wires: pulled high unless the device drives low
  assign readyWire = readyToConfigureNOeN ? 1'b1 : readyToConfigureNOut;
  assign doneWire = doneOeN ? 1'b1 : doneOut;
  cfg_host_model host (.core_clk, .programRequestN, .modePins, .configClock, .parChipSelN,
    .parWriteN, .parData);
  config_port_control uut (.core_clk, .sys_rst, .programRequestN, .modePins, .configClock,
    .parChipSelN, .parWriteN, .parData, .parBusy, .readyToConfigureNIn(readyWire),
    .readyToConfigureNOut, .readyToConfigureNOeN, .doneIn(doneWire), .doneOut, .doneOeN,
    .tapConfigCmd, .tapDataValid, .tapDataReady, .tapData, .tapRefused, .cfgWord,
    .cfgWordValid, .cfgWordReady, .configComplete, .latchedMode, .lockedPort,
    .startupActive, .userMode, .dataOverrun, .doneSeen);
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // scoreboard: sampled mid-cycle, the pop happens at the next edge
  always @(negedge core_clk) begin
    if (!sys_rst && cfgWordValid === 1'b1 && cfgWordReady === 1'b1) begin
      if (expQ.size() == 0) check("extraWord", 16'h0001, 16'h0000);
      else check("cfgWord", 16'(cfgWord), 16'(expQ.pop_front()));
    end
  end
  // watchdog well past the expected run of some 500 cycles
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------
  task automatic power_up();
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  // bounded wait for the ready pin, then time for the mode latch
  task automatic wait_ready();
    for (k = 0; k < 300 && readyToConfigureNOeN !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    check("clearLen", 16'(k >= CLEAR_CYCLES - 3 && k < CLEAR_CYCLES + 20), 16'h0001);
    repeat (6) @(posedge core_clk);
  endtask
  // valid held until ready is seen; lowering is left to the caller
  task automatic tap_beat(input logic [DATA_W-1:0] v);
    tapDataValid <= 1'b1;
    tapData <= v;
    expQ.push_back('{PORT_TAP, v});
    @(negedge core_clk);
    for (k = 0; k < 50 && tapDataReady !== 1'b1; k++) @(negedge core_clk);
    check("tapReady", 16'(tapDataReady), 16'h0001);
    @(posedge core_clk);
  endtask
  task automatic pulse_cmd();
    @(posedge core_clk);
    tapConfigCmd <= 1'b1;
    @(posedge core_clk);
    tapConfigCmd <= 1'b0;
    #1;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    power_up();
    check("readyOe", 16'(readyToConfigureNOeN), 16'h0000);
    check("doneOe", 16'(doneOeN), 16'h0000);
    check("lockNone", 16'(lockedPort), 16'(PORT_NONE));
    check("odLow", 16'({readyToConfigureNOut, doneOut}), 16'h0000);
    wait_ready();
    check("mode", 16'(latchedMode), 16'(MODE_SLAVE_PARALLEL));
    $display("test reset_and_mode done");
    // engine stalled: two beats beyond the buffer are dropped
    for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
      d = 8'($random(seed));
      if (i < FIFO_DEPTH) expQ.push_back('{PORT_PINS, d});
      host.send_beat(d);
    end
    repeat (4) @(posedge core_clk);
    #1 check("busy", 16'(parBusy), 16'h0001);
    check("overrun", 16'(dataOverrun), 16'h0001);
    check("lockPins", 16'(lockedPort), 16'(PORT_PINS));
    pulse_cmd();
    check("tapRefused", 16'(tapRefused), 16'h0001);
    @(posedge core_clk);
    cfgWordReady <= 1'b1;
    for (k = 0; k < 200 && expQ.size() > 0; k++) @(posedge core_clk);
    #1 check("drained", 16'(expQ.size()), 16'h0000);
    check("busyOff", 16'(parBusy), 16'h0000);
    $display("test pin_load done");
    @(posedge core_clk);
    configComplete <= 1'b1;
    @(posedge core_clk);
    configComplete <= 1'b0;
    #1 check("doneRel", 16'(doneOeN), 16'h0001);
    check("startup", 16'(startupActive), 16'h0001);
    for (k = 0; k < 40 && userMode !== 1'b1; k++) @(posedge core_clk);
    #1 check("user", 16'(userMode), 16'h0001);
    check("doneSeen", 16'(doneSeen), 16'h0001);
    host.pulse_program();
    repeat (4) @(posedge core_clk);
    #1 check("restartOe", 16'(readyToConfigureNOeN), 16'h0000);
    check("restartDone", 16'(doneOeN), 16'h0000);
    check("lockKept", 16'(lockedPort), 16'(PORT_PINS));
    check("overrunClr", 16'(dataOverrun), 16'h0000);
    $display("test startup_restart done");
    // a fresh power-up frees the lock for the test port
    power_up();
    pulse_cmd();
    check("lockTap", 16'(lockedPort), 16'(PORT_TAP));
    check("tapClear", 16'(readyToConfigureNOeN), 16'h0000);
    wait_ready();
    host.send_beat(8'h3c); // pin beat must be ignored under test port lock
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) tap_beat(8'($random(seed)));
    tapDataValid <= 1'b0;
    for (k = 0; k < 100 && expQ.size() > 0; k++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    #1 check("tapDrained", 16'(expQ.size()), 16'h0000);
    $display("test tap_load done");
    print_verdict();
  end
endmodule
bind config_port_control config_port_control_assertions chk (.core_clk, .sys_rst,
  .programRequestN, .modePins, .tapConfigCmd, .readyToConfigureNOeN, .doneOeN,
  .tapRefused, .latchedMode, .lockedPort, .startupActive, .userMode);
